// ### boie_alu.sv
// combinational result and flag logic for one instruction
`timescale 1ns/1ns
`default_nettype none
`include "boie_params.svh"
module boie_alu (
   input wire boie_pkg::boie_op_t op,
   input wire logic [`BOIE_DATA_W-1:0] acc,
   input wire logic [`BOIE_DATA_W-1:0] file_val,
   input wire logic carry_in,
   output logic [`BOIE_DATA_W-1:0] result,
   output logic carry_out
);
   wire logic [`BOIE_DATA_W-1:0] or_val;
   wire logic [`BOIE_DATA_W-1:0] rl_val;
   wire logic [`BOIE_DATA_W-1:0] rr_val;

   assign or_val = acc | file_val;
   assign rl_val = {file_val[`BOIE_MSB-1:`BOIE_LSB], carry_in};
   assign rr_val = {carry_in, file_val[`BOIE_MSB:`BOIE_LSB+1]};

   always_comb begin
      result = file_val;
      carry_out = carry_in;
      case (op)
         boie_pkg::BOIE_OP_OR_ACC_WITH_FILE: result = or_val;
         boie_pkg::BOIE_OP_STORE_ACC_TO_FILE: result = acc;
         boie_pkg::BOIE_OP_MOVE_FILE: result = file_val;
         boie_pkg::BOIE_OP_ROTATE_LEFT_CARRY: begin
            result = rl_val;
            carry_out = file_val[`BOIE_MSB];
         end
         boie_pkg::BOIE_OP_ROTATE_RIGHT_CARRY: begin
            result = rr_val;
            carry_out = file_val[`BOIE_LSB];
         end
         default: result = file_val;
      endcase
   end
endmodule // boie_alu
`default_nettype wire

// ### boie_exec.sv
// executor for OR, moves, rotates, returns and no-op of an 8-bit core
`timescale 1ns/1ns
`default_nettype none
`include "boie_params.svh"
// How it works
// - or_acc_with_file ORs accumulator with file register, zero flag from result
// - direction bit 0 writes accumulator, 1 writes back to file register
// - store_acc_to_file copies accumulator to file register, flags untouched
// - move_file copies file register to direction-selected destination
// - move_file sets zero flag from moved value, acting as a test
// - return_with_literal loads accumulator with literal, pc from stack_top, flags untouched
// - return_with_literal takes two instruction cycles
// - rotate_left_carry: old carry into bit 0, old bit 7 to carry
// - rotate_right_carry: old carry into bit 7, old bit 0 to carry
module boie_exec #(
   parameter int DATA_W = `BOIE_DATA_W,
   parameter int ADDR_W = `BOIE_ADDR_W,
   parameter int PC_W = `BOIE_PC_W
) (
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic instr_valid,
   input wire boie_pkg::boie_instr_t instr,
   input wire logic [DATA_W-1:0] file_rd_data,
   input wire logic [PC_W-1:0] stack_top,
   output logic instr_ready,
   output logic [ADDR_W-1:0] file_addr,
   output logic file_wr_en,
   output logic [DATA_W-1:0] file_wr_data,
   output logic [DATA_W-1:0] acc_reg,
   output boie_pkg::boie_flags_t flags_reg,
   output logic global_irq_enable_reg,
   output logic [PC_W-1:0] pc_load_value_reg,
   output logic pc_load_reg,
   output logic stack_pop
);
   if (DATA_W != `BOIE_DATA_W || ADDR_W != `BOIE_ADDR_W || PC_W < 1) begin : g_width_check
      $error("boie_exec: unsupported width");
   end

   ////////////////////////////////////////////////////////////////////////
   // decode
   logic busy_reg;
   logic busy_next;
   wire logic take;
   wire logic is_or;
   wire logic is_store;
   wire logic is_move;
   wire logic is_rl;
   wire logic is_rr;
   wire logic is_return_with_literal;
   wire logic is_return_from_irq;
   wire logic has_dest;
   wire logic to_acc;
   wire logic to_file;
   wire logic [DATA_W-1:0] alu_result;
   wire logic alu_carry;
   wire logic result_zero;

   // second cycle of a return is a forced no-op, so no new instruction is taken
   assign instr_ready = !busy_reg;
   // a core held in reset executes nothing, so no file write can slip out
   assign take = instr_valid && instr_ready && !rst;
   assign is_or = take && instr.op == boie_pkg::BOIE_OP_OR_ACC_WITH_FILE;
   assign is_store = take && instr.op == boie_pkg::BOIE_OP_STORE_ACC_TO_FILE;
   assign is_move = take && instr.op == boie_pkg::BOIE_OP_MOVE_FILE;
   assign is_rl = take && instr.op == boie_pkg::BOIE_OP_ROTATE_LEFT_CARRY;
   assign is_rr = take && instr.op == boie_pkg::BOIE_OP_ROTATE_RIGHT_CARRY;
   assign is_return_with_literal = take && instr.op == boie_pkg::BOIE_OP_RETURN_WITH_LITERAL;
   assign is_return_from_irq = take && instr.op == boie_pkg::BOIE_OP_RETURN_FROM_IRQ;
   assign has_dest = is_or || is_move || is_rl || is_rr;
   assign to_acc = has_dest && instr.dest == `BOIE_DEST_ACC;
   assign to_file = (has_dest && instr.dest == `BOIE_DEST_FILE) || is_store;
   assign result_zero = alu_result == '0;

   boie_alu u_alu (
      .op(instr.op),
      .acc(acc_reg),
      .file_val(file_rd_data),
      .carry_in(flags_reg.carry),
      .result(alu_result),
      .carry_out(alu_carry)
   );

   ////////////////////////////////////////////////////////////////////////
   // file register port is combinational, written at the end of the cycle
   assign file_addr = instr.file_addr;
   assign file_wr_en = to_file;
   assign file_wr_data = alu_result;
   assign stack_pop = is_return_with_literal || is_return_from_irq;

   ////////////////////////////////////////////////////////////////////////
   // next values, selected here so the clocked blocks stay short
   wire logic [DATA_W-1:0] acc_next;
   wire logic zero_upd;
   wire logic carry_upd;
   wire logic zero_next;
   wire logic carry_next;
   wire logic global_irq_enable_next;
   wire logic [PC_W-1:0] pc_load_value_next;

   assign busy_next = is_return_with_literal || is_return_from_irq;
   assign acc_next = to_acc ? alu_result : is_return_with_literal ? instr.literal : acc_reg;
   // only or and move touch zero, only rotates touch carry; everything else holds both
   assign zero_upd = is_or || is_move;
   assign carry_upd = is_rl || is_rr;
   assign zero_next = zero_upd ? result_zero : flags_reg.zero;
   assign carry_next = carry_upd ? alu_carry : flags_reg.carry;
   assign global_irq_enable_next = is_return_from_irq || global_irq_enable_reg;
   assign pc_load_value_next = stack_pop ? stack_top : pc_load_value_reg;

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         busy_reg <= 1'b0;
         pc_load_reg <= 1'b0;
         pc_load_value_reg <= '0;
      end else begin
         busy_reg <= busy_next;
         pc_load_reg <= stack_pop;
         pc_load_value_reg <= pc_load_value_next;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (rst)
         acc_reg <= `BOIE_ACC_RESET;
      else
         acc_reg <= acc_next;
   end

   always_ff @(posedge ref_clk) begin
      if (rst)
         flags_reg <= {`BOIE_FLAG_RESET, `BOIE_FLAG_RESET};
      else
         flags_reg <= {zero_next, carry_next};
   end

   always_ff @(posedge ref_clk) begin
      if (rst)
         global_irq_enable_reg <= `BOIE_FLAG_RESET;
      else
         global_irq_enable_reg <= global_irq_enable_next;
   end

   ////////////////////////////////////////////////////////////////////////
   // checks
   or_zero_flag_a: assert property (@(posedge ref_clk) disable iff (rst)
      is_or |=> flags_reg.zero == (($past(acc_reg) | $past(file_rd_data)) == '0))
      else $error("zero flag wrong after or");
   dest_select_a: assert property (@(posedge ref_clk) disable iff (rst)
      has_dest |-> (file_wr_en == instr.dest))
      else $error("destination select wrong");
   store_flags_a: assert property (@(posedge ref_clk) disable iff (rst)
      is_store |-> file_wr_data == acc_reg ##1 $stable(flags_reg))
      else $error("store changed flags or data");
   move_dest_a: assert property (@(posedge ref_clk) disable iff (rst)
      is_move && instr.dest == `BOIE_DEST_ACC |=> acc_reg == $past(file_rd_data))
      else $error("move to accumulator wrong");
   move_zero_a: assert property (@(posedge ref_clk) disable iff (rst)
      is_move |=> flags_reg.zero == ($past(file_rd_data) == '0))
      else $error("move zero test wrong");
   return_with_literal_load_a: assert property (@(posedge ref_clk) disable iff (rst)
      is_return_with_literal |=> acc_reg == $past(instr.literal) && pc_load_reg && $stable(flags_reg))
      else $error("literal return wrong");
   return_with_literal_cycles_a: assert property (@(posedge ref_clk) disable iff (rst)
      is_return_with_literal |=> !instr_ready ##1 instr_ready)
      else $error("literal return not two cycles");
   rotl_carry_a: assert property (@(posedge ref_clk) disable iff (rst)
      is_rl |-> alu_result[`BOIE_LSB] == flags_reg.carry ##1 flags_reg.carry == $past(file_rd_data[`BOIE_MSB]))
      else $error("rotate left wrong");
   rotr_carry_a: assert property (@(posedge ref_clk) disable iff (rst)
      is_rr |-> alu_result[`BOIE_MSB] == flags_reg.carry ##1 flags_reg.carry == $past(file_rd_data[`BOIE_LSB]))
      else $error("rotate right wrong");
   return_from_irq_gie_a: assert property (@(posedge ref_clk) disable iff (rst)
      is_return_from_irq |=> global_irq_enable_reg && pc_load_value_reg == $past(stack_top) && $stable(flags_reg))
      else $error("irq return wrong");
   nop_quiet_a: assert property (@(posedge ref_clk) disable iff (rst)
      take && instr.op == boie_pkg::BOIE_OP_NOP |-> !file_wr_en ##1 $stable(acc_reg) && $stable(flags_reg)
         && instr_ready)
      else $error("no-op changed state");
   store_addr_a: assert property (@(posedge ref_clk) disable iff (rst)
      is_store |-> file_wr_en && file_addr == instr.file_addr && !stack_pop)
      else $error("store address or enable wrong");
   or_result_a: assert property (@(posedge ref_clk) disable iff (rst)
      is_or |-> alu_result == (acc_reg | file_rd_data))
      else $error("or result wrong");
   or_to_acc_a: assert property (@(posedge ref_clk) disable iff (rst)
      is_or && instr.dest == `BOIE_DEST_ACC |=> acc_reg == ($past(acc_reg) | $past(file_rd_data)))
      else $error("or to accumulator wrong");
   file_back_a: assert property (@(posedge ref_clk) disable iff (rst)
      has_dest && instr.dest == `BOIE_DEST_FILE |-> file_wr_en ##1 $stable(acc_reg))
      else $error("write back touched accumulator");
   move_back_a: assert property (@(posedge ref_clk) disable iff (rst)
      is_move && instr.dest == `BOIE_DEST_FILE |-> file_wr_data == file_rd_data)
      else $error("move back changed data");
   return_with_literal_pc_a: assert property (@(posedge ref_clk) disable iff (rst)
      is_return_with_literal |=> pc_load_value_reg == $past(stack_top))
      else $error("literal return pc wrong");
   // the second cycle of a return must refuse whatever still stands on the inputs
   return_with_literal_refuse_a: assert property (@(posedge ref_clk) disable iff (rst)
      is_return_with_literal |-> stack_pop ##1 !stack_pop && !file_wr_en)
      else $error("second return cycle not idle");
   pc_pulse_a: assert property (@(posedge ref_clk) disable iff (rst)
      pc_load_reg |-> !instr_ready ##1 !pc_load_reg)
      else $error("pc load not a single pulse");
   rotl_acc_a: assert property (@(posedge ref_clk) disable iff (rst)
      is_rl && instr.dest == `BOIE_DEST_ACC |=>
         acc_reg == {$past(file_rd_data[`BOIE_MSB-1:`BOIE_LSB]), $past(flags_reg.carry)})
      else $error("rotate left to accumulator wrong");
   rotr_file_a: assert property (@(posedge ref_clk) disable iff (rst)
      is_rr && instr.dest == `BOIE_DEST_FILE |-> file_wr_en
         && file_wr_data == {flags_reg.carry, file_rd_data[`BOIE_MSB:`BOIE_LSB+1]})
      else $error("rotate right to file wrong");
   rotate_zero_a: assert property (@(posedge ref_clk) disable iff (rst)
      is_rl || is_rr |=> $stable(flags_reg.zero))
      else $error("rotate changed zero flag");
   return_from_irq_acc_a: assert property (@(posedge ref_clk) disable iff (rst)
      is_return_from_irq |=> $stable(acc_reg) && pc_load_reg && !instr_ready)
      else $error("irq return touched accumulator");
   gie_hold_a: assert property (@(posedge ref_clk) disable iff (rst)
      global_irq_enable_reg |=> global_irq_enable_reg)
      else $error("irq enable dropped");
   nop_no_pop_a: assert property (@(posedge ref_clk) disable iff (rst)
      take && instr.op == boie_pkg::BOIE_OP_NOP |-> !stack_pop ##1 $stable(global_irq_enable_reg) && !pc_load_reg)
      else $error("no-op touched stack or irq enable");
endmodule // boie_exec
`default_nettype wire

// ### boie_params.svh
// constants for the byte-op instruction executor
`ifndef BOIE_PARAMS_SVH
`define BOIE_PARAMS_SVH
`define BOIE_DATA_W 8
`define BOIE_ADDR_W 7
`define BOIE_PC_W 13
`define BOIE_ACC_RESET 8'h00
`define BOIE_FLAG_RESET 1'b0
`define BOIE_DEST_ACC 1'b0
`define BOIE_DEST_FILE 1'b1
`define BOIE_MSB 7
`define BOIE_LSB 0
`define BOIE_FILE_DEPTH 128
`endif

// ### boie_pkg.sv
// types for the byte-op instruction executor
`default_nettype none
`include "boie_params.svh"
package boie_pkg;
   typedef enum logic [2:0] {
      BOIE_OP_NOP,
      BOIE_OP_OR_ACC_WITH_FILE,
      BOIE_OP_STORE_ACC_TO_FILE,
      BOIE_OP_MOVE_FILE,
      BOIE_OP_RETURN_FROM_IRQ,
      BOIE_OP_RETURN_WITH_LITERAL,
      BOIE_OP_ROTATE_LEFT_CARRY,
      BOIE_OP_ROTATE_RIGHT_CARRY
   } boie_op_t;

   typedef struct packed {
      boie_op_t op;
      logic [`BOIE_ADDR_W-1:0] file_addr;
      logic dest;
      logic [`BOIE_DATA_W-1:0] literal;
   } boie_instr_t;

   typedef struct packed {
      logic zero;
      logic carry;
   } boie_flags_t;
endpackage
`default_nettype wire

// ### tb_byte_op_instruction_exec.sv
// self-checking testbench for the byte-op instruction executor
`timescale 1ns/1ns
`default_nettype none
module tb_byte_op_instruction_exec;
   logic ref_clk;
   logic rst;
   logic instr_valid;
   boie_pkg::boie_instr_t instr;
   logic [7:0] mem [0:127];
   logic [12:0] stack_top;
   logic instr_ready;
   logic [6:0] file_addr;
   logic file_wr_en;
   logic [7:0] file_wr_data;
   logic [7:0] acc_reg;
   boie_pkg::boie_flags_t flags_reg;
   logic global_irq_enable_reg;
   logic [12:0] pc_load_value_reg;
   logic pc_load_reg;
   logic stack_pop;
   logic [7:0] e_acc = 8'h00;
   logic e_z = 1'b0;
   logic e_c = 1'b0;
   logic e_gie = 1'b0;
   int bad_count = 0;
   int samples_checked = 0;
   boie_exec boie_exec_inst (.ref_clk(ref_clk), .rst(rst), .instr_valid(instr_valid), .instr(instr),
      .file_rd_data(mem[file_addr]), .stack_top(stack_top), .instr_ready(instr_ready), .file_addr(file_addr),
      .file_wr_en(file_wr_en), .file_wr_data(file_wr_data), .acc_reg(acc_reg), .flags_reg(flags_reg),
      .global_irq_enable_reg(global_irq_enable_reg), .pc_load_value_reg(pc_load_value_reg),
      .pc_load_reg(pc_load_reg), .stack_pop(stack_pop));
   // file memory writes on the same edge that takes the instruction
   always @(posedge ref_clk) begin
      if (file_wr_en === 1'b1) mem[file_addr] <= file_wr_data;
   end
   initial begin
      ref_clk = 1'b0;
      forever #50 ref_clk = ~ref_clk;
   end
   ////////////////////////////////////////////////////////////////////////////
   task automatic report_and_stop();
      if (bad_count == 0 && samples_checked > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   // every kind of result funnels into one tally so the mismatch line keeps one format
   task automatic tally(input logic ok, input logic [12:0] got, input logic [12:0] exp);
      samples_checked++;
      if (ok !== 1'b1) begin
         bad_count++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic check_byte(input logic [7:0] got, input logic [7:0] exp);
      tally(got === exp, 13'(got), 13'(exp));
   endtask
   task automatic check_bit(input logic got, input logic exp);
      tally(got === exp, 13'(got), 13'(exp));
   endtask
   task automatic check_flags(input boie_pkg::boie_flags_t got, input boie_pkg::boie_flags_t exp);
      tally(got === exp, 13'(got), 13'(exp));
   endtask
   task automatic check_pc(input logic [12:0] got, input logic [12:0] exp);
      tally(got === exp, got, exp);
   endtask
   // result of one instruction before it is steered to its destination
   function automatic logic [7:0] expect_result(input boie_pkg::boie_op_t op, input logic [7:0] acc,
      input logic [7:0] f, input logic c);
      case (op)
         boie_pkg::BOIE_OP_OR_ACC_WITH_FILE: return acc | f;
         boie_pkg::BOIE_OP_STORE_ACC_TO_FILE: return acc;
         boie_pkg::BOIE_OP_ROTATE_LEFT_CARRY: return {f[6:0], c};
         boie_pkg::BOIE_OP_ROTATE_RIGHT_CARRY: return {c, f[7:1]};
         default: return f;
      endcase
   endfunction
   // reset clears the core but leaves the file registers as they are
   task automatic apply_reset();
      instr_valid = 1'b0;
      rst = 1'b1;
      repeat (8) @(negedge ref_clk);
      e_acc = 8'h00;
      e_z = 1'b0;
      e_c = 1'b0;
      e_gie = 1'b0;
      check_byte(acc_reg, e_acc);
      check_flags(flags_reg, {e_z, e_c});
      check_bit(global_irq_enable_reg, e_gie);
      check_bit(pc_load_reg, 1'b0);
      check_bit(instr_ready, 1'b1);
      rst = 1'b0;
   endtask
   // one instruction from drive to settled result, returns include their refused second cycle
   task automatic run(input boie_pkg::boie_op_t op, input logic [6:0] a, input logic d, input logic [7:0] k);
      logic [7:0] f;
      logic [7:0] r;
      logic [7:0] nf;
      logic [12:0] top;
      logic ret;
      logic alu;
      logic wr;
      f = mem[a];
      top = 13'($urandom);
      ret = op inside {boie_pkg::BOIE_OP_RETURN_FROM_IRQ, boie_pkg::BOIE_OP_RETURN_WITH_LITERAL};
      alu = op inside {boie_pkg::BOIE_OP_OR_ACC_WITH_FILE, boie_pkg::BOIE_OP_MOVE_FILE,
         boie_pkg::BOIE_OP_ROTATE_LEFT_CARRY, boie_pkg::BOIE_OP_ROTATE_RIGHT_CARRY};
      r = expect_result(op, e_acc, f, e_c);
      wr = (op == boie_pkg::BOIE_OP_STORE_ACC_TO_FILE) || (alu && d);
      if (op == boie_pkg::BOIE_OP_OR_ACC_WITH_FILE || op == boie_pkg::BOIE_OP_MOVE_FILE) e_z = (r == 8'h00);
      if (op == boie_pkg::BOIE_OP_ROTATE_LEFT_CARRY) e_c = f[7];
      if (op == boie_pkg::BOIE_OP_ROTATE_RIGHT_CARRY) e_c = f[0];
      if (op == boie_pkg::BOIE_OP_RETURN_FROM_IRQ) e_gie = 1'b1;
      nf = wr ? r : f;
      if (alu && !d) e_acc = r;
      if (op == boie_pkg::BOIE_OP_RETURN_WITH_LITERAL) e_acc = k;
      instr_valid = 1'b1;
      instr = {op, a, d, k};
      stack_top = top;
      #1;
      check_bit(stack_pop, ret);
      check_byte({1'b0, file_addr}, {1'b0, a});
      check_bit(file_wr_en, wr);
      if (wr) check_byte(file_wr_data, r);
      @(negedge ref_clk);
      check_byte(acc_reg, e_acc);
      check_flags(flags_reg, {e_z, e_c});
      check_bit(global_irq_enable_reg, e_gie);
      check_byte(mem[a], nf);
      check_bit(pc_load_reg, ret);
      check_bit(instr_ready, !ret);
      if (ret) begin
         check_pc(pc_load_value_reg, top);
         // the return stays on the inputs through its second cycle, which must refuse it
         #1;
         check_bit(stack_pop, 1'b0);
         check_bit(file_wr_en, 1'b0);
         @(negedge ref_clk);
         check_byte(acc_reg, e_acc);
         check_bit(pc_load_reg, 1'b0);
         check_bit(instr_ready, 1'b1);
      end
   endtask
   ////////////////////////////////////////////////////////////////////////////
   initial begin
      instr = '0;
      stack_top = 13'h0000;
      void'($urandom(32'h8987));
      for (int i = 0; i < 128; i++) mem[i] = 8'($urandom);
      apply_reset();
      run(boie_pkg::BOIE_OP_STORE_ACC_TO_FILE, 7'h7f, 1'b0, 8'h00);
      run(boie_pkg::BOIE_OP_MOVE_FILE, 7'h7f, 1'b1, 8'h00);
      run(boie_pkg::BOIE_OP_RETURN_WITH_LITERAL, 7'h00, 1'b0, 8'hff);
      run(boie_pkg::BOIE_OP_STORE_ACC_TO_FILE, 7'h01, 1'b0, 8'h00);
      run(boie_pkg::BOIE_OP_ROTATE_LEFT_CARRY, 7'h01, 1'b1, 8'h00);
      run(boie_pkg::BOIE_OP_ROTATE_RIGHT_CARRY, 7'h01, 1'b0, 8'h00);
      run(boie_pkg::BOIE_OP_OR_ACC_WITH_FILE, 7'h00, 1'b1, 8'h00);
      run(boie_pkg::BOIE_OP_RETURN_FROM_IRQ, 7'h00, 1'b0, 8'h00);
      run(boie_pkg::BOIE_OP_NOP, 7'h01, 1'b1, 8'h5a);
      // a second reset mid-run, then the first instruction right at its release
      apply_reset();
      for (int i = 0; i < 400; i++) begin
         run(boie_pkg::boie_op_t'(3'($urandom)), 7'($urandom), 1'($urandom), 8'($urandom));
      end
      report_and_stop();
   end
   // watchdog well beyond the roughly 530 cycles the tests need
   initial begin
      #500000;
      bad_count++;
      report_and_stop();
   end
endmodule // tb_byte_op_instruction_exec
`default_nettype wire
